/* src/pfm_pkg.sv */
// Constants shared by the parallel flash mode controller
package pfm_pkg;

    // Core clock period
    localparam int CLK_PERIOD_PS = 8000;

    // Pin timing in nanoseconds (plain defaults for the attached part)
    localparam int ACCESS_NS      = 70;    // address_access_time
    localparam int WR_SETUP_NS    = 10;
    localparam int WR_PULSE_NS    = 35;
    localparam int WR_HOLD_NS     = 20;
    localparam int RST_PULSE_NS   = 500;   // restart_pulse_min
    localparam int RST_READY_NS   = 20000; // restart completion time
    localparam int RST_TO_READ_NS = 50;    // restart_to_read_delay
    localparam int SYNC_STAGES    = 3;

    // Least time in cycles, rounded up, never below one
    function automatic logic [11:0] minCycles(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        if (c < 1) begin
            c = 1;
        end
        return c[11:0];
    endfunction

    // Cycle counts derived from the times above
    localparam logic [11:0] ACCESS_CYC      = minCycles(ACCESS_NS);
    localparam logic [11:0] WR_SETUP_CYC    = minCycles(WR_SETUP_NS);
    localparam logic [11:0] WR_PULSE_CYC    = minCycles(WR_PULSE_NS);
    localparam logic [11:0] WR_HOLD_CYC     = minCycles(WR_HOLD_NS);
    localparam logic [11:0] RST_PULSE_CYC   = minCycles(RST_PULSE_NS);
    localparam logic [11:0] RST_READY_CYC   = 12'((RST_READY_NS * 1000) / CLK_PERIOD_PS);
    localparam logic [11:0] RST_TO_READ_CYC = minCycles(RST_TO_READ_NS);
    localparam logic [11:0] SYNC_CYC        = 12'(SYNC_STAGES);

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] ADDR_OFS   = 8'h04;
    localparam logic [7:0] WDATA_OFS  = 8'h08;
    localparam logic [7:0] RDATA_OFS  = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // Control fields
    localparam int CTRL_GO_BIT    = 0;
    localparam int CTRL_OP_LSB    = 1;
    localparam int CTRL_ACCEL_BIT = 3;
    localparam int CTRL_WP_BIT    = 4;
    localparam logic [1:0] CTRL_OP_RST   = 2'h0;
    localparam logic       CTRL_ACCEL_RST = 1'b0;
    localparam logic       CTRL_WP_RST    = 1'b1;

    // Status fields
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_RB_BIT    = 1;
    localparam int STAT_HV_BIT    = 2;
    localparam int STAT_INTR_BIT  = 3;
    localparam int STAT_REFUS_BIT = 4;

    // Operations started by the go bit
    typedef enum logic [1:0] {
        OP_READ    = 2'b00,
        OP_WRITE   = 2'b01,
        OP_ACCPROG = 2'b10,
        OP_RESTART = 2'b11
    } pfm_op_e;

    // Pin sequencer states
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_RD_WAIT  = 3'b001,
        ST_WR_SETUP = 3'b010,
        ST_WR_PULSE = 3'b011,
        ST_WR_HOLD  = 3'b100,
        ST_RST_LOW  = 3'b101,
        ST_RST_RDY  = 3'b110,
        ST_RST_HOLD = 3'b111
    } pfm_state_e;

endpackage

/* src/pfm_host_ctrl.sv */
// Host-side controller driving a multi-bank parallel NOR flash over its pins
//
// How it works
// - Accelerated program issues exactly two write cycles: command word, then data.
// - High voltage only while accel programming is enabled; reads are refused then.
// - Protect level and high-voltage enable are always driven, never floating.
// - Restart during busy sets a sticky flag so software reissues the operation.
// - After restart release no operation starts before the restart-to-read delay.
// - A write cycle drops write enable and chip select with output enable high.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module pfm_host_ctrl
    import pfm_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Flash control pins
    output logic                   flashCeN,
    output logic                   flashOeN,
    output logic                   flashWeN,
    output logic                   flashRestartN,
    output logic [ADDR_W-1:0]      flashAddr,
    input  wire logic              readyBusyN,
    // Protect/accelerate pin drive
    output logic                   protectAccelLevel,
    output logic                   highAccelVoltageEn,
    // Data lines
    input  wire logic [DATA_W-1:0] dqIn,
    output logic [DATA_W-1:0]      dqOut,
    output logic                   dqOe
);

    ////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic              apValid_q;
    logic              apWrite_q;
    logic [7:0]        apOfs_q;
    logic [31:0]       hrdata_q;
    logic [1:0]        op_q;
    logic              accelEn_q;
    logic              wpLevel_q;
    logic [ADDR_W-1:0] addrReg_q;
    logic [31:0]       wdataReg_q;
    logic [DATA_W-1:0] rdataReg_q;
    logic              intrFlag_q;
    logic              refusFlag_q;
    pfm_state_e        state_q;
    pfm_state_e        state_d;
    logic [11:0]       cnt_q;
    logic [11:0]       cnt_d;
    logic              secondPend_q;
    logic [2:0]        rbSync_q;
    logic              rbStable_q;
    logic [DATA_W-1:0] dqS1_q;
    logic [DATA_W-1:0] dqS2_q;
    logic [DATA_W-1:0] dqS3_q;

    // Address phase decode and data phase write strobes
    wire        apTake   = hsel & hready & htrans[1];
    wire        dpWr     = apValid_q & apWrite_q;
    wire        wrCtrl   = dpWr & (apOfs_q == CTRL_OFS);
    wire        wrAddr   = dpWr & (apOfs_q == ADDR_OFS);
    wire        wrWdata  = dpWr & (apOfs_q == WDATA_OFS);
    wire        wrStatus = dpWr & (apOfs_q == STATUS_OFS);
    wire        goReq    = wrCtrl & hwdata[CTRL_GO_BIT];
    wire [1:0]  goOp     = hwdata[CTRL_OP_LSB +: 2];
    wire        idle     = (state_q == ST_IDLE);
    wire        needAcc  = (goOp == OP_ACCPROG);
    wire        badRead  = (goOp == OP_READ) & (accelEn_q | hwdata[CTRL_ACCEL_BIT]);
    wire        badAcc   = needAcc & ~hwdata[CTRL_ACCEL_BIT];
    wire        goOk     = goReq & idle & ~badRead & ~badAcc;
    wire        refuse   = goReq & ~goOk;
    wire        rstStart = (state_q == ST_RST_LOW) & (cnt_q == RST_PULSE_CYC);
    wire        intrSet  = rstStart & ~rbStable_q;

    // Read mux for the register in address phase
    wire [31:0] ctrlRd   = {27'h0, wpLevel_q, accelEn_q, op_q, 1'b0};
    wire [31:0] statRd   = {27'h0, refusFlag_q, intrFlag_q, accelEn_q, rbStable_q, ~idle};
    wire [31:0] rdMux    = (haddr[7:0] == CTRL_OFS)   ? ctrlRd :
                           (haddr[7:0] == ADDR_OFS)   ? 32'(addrReg_q) :
                           (haddr[7:0] == WDATA_OFS)  ? wdataReg_q :
                           (haddr[7:0] == RDATA_OFS)  ? 32'(rdataReg_q) :
                           (haddr[7:0] == STATUS_OFS) ? statRd : 32'h0;

    // Zero wait state slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // Address phase capture
    always_ff @(posedge core_clk) begin
        if (rst) begin
            apValid_q <= 1'b0;
            apWrite_q <= 1'b0;
            apOfs_q   <= 8'h0;
            hrdata_q  <= 32'h0;
        end else begin
            apValid_q <= apTake;
            apWrite_q <= hwrite;
            apOfs_q   <= haddr[7:0];
            hrdata_q  <= (apTake & ~hwrite) ? rdMux : hrdata_q;
        end
    end

    // Control, address and data registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            op_q       <= CTRL_OP_RST;
            accelEn_q  <= CTRL_ACCEL_RST;
            wpLevel_q  <= CTRL_WP_RST;
            addrReg_q  <= '0;
            wdataReg_q <= 32'h0;
        end else begin
            op_q       <= wrCtrl ? goOp : op_q;
            accelEn_q  <= wrCtrl ? hwdata[CTRL_ACCEL_BIT] : accelEn_q;
            wpLevel_q  <= wrCtrl ? hwdata[CTRL_WP_BIT] : wpLevel_q;
            addrReg_q  <= wrAddr ? hwdata[ADDR_W-1:0] : addrReg_q;
            wdataReg_q <= wrWdata ? hwdata : wdataReg_q;
        end
    end

    // Sticky flags, write one to clear, a set in the same cycle wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            intrFlag_q  <= 1'b0;
            refusFlag_q <= 1'b0;
        end else begin
            intrFlag_q  <= intrSet | (intrFlag_q & ~(wrStatus & hwdata[STAT_INTR_BIT]));
            refusFlag_q <= refuse | (refusFlag_q & ~(wrStatus & hwdata[STAT_REFUS_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers

    // Ready/busy passes three stages; a change counts when stages two and three agree
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rbSync_q   <= 3'b111;
            rbStable_q <= 1'b1;
        end else begin
            rbSync_q   <= {rbSync_q[1:0], readyBusyN};
            rbStable_q <= (rbSync_q[1] == rbSync_q[2]) ? rbSync_q[2] : rbStable_q;
        end
    end

    // Data lines pass three stages before capture
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dqS1_q <= '0;
            dqS2_q <= '0;
            dqS3_q <= '0;
        end else begin
            dqS1_q <= dqIn;
            dqS2_q <= dqS1_q;
            dqS3_q <= dqS2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin sequencer

    wire cntDone = (cnt_q == 12'h0);
    wire cntDec  = ~cntDone;
    wire rdyTmo  = cntDone & (state_q == ST_RST_RDY);

    // Next state and interval count
    always_comb begin
        state_d = state_q;
        cnt_d   = cntDec ? cnt_q - 12'h1 : cnt_q;
        unique case (state_q)
            ST_IDLE: begin
                if (goOk) begin
                    unique case (goOp)
                        OP_READ: begin
                            state_d = ST_RD_WAIT;
                            cnt_d   = ACCESS_CYC + SYNC_CYC;
                        end
                        OP_WRITE, OP_ACCPROG: begin
                            state_d = ST_WR_SETUP;
                            cnt_d   = WR_SETUP_CYC;
                        end
                        OP_RESTART: begin
                            state_d = ST_RST_LOW;
                            cnt_d   = RST_PULSE_CYC;
                        end
                    endcase
                end
            end
            ST_RD_WAIT: begin
                if (cntDone) begin
                    state_d = ST_IDLE;
                end
            end
            ST_WR_SETUP: begin
                if (cntDone) begin
                    state_d = ST_WR_PULSE;
                    cnt_d   = WR_PULSE_CYC;
                end
            end
            ST_WR_PULSE: begin
                if (cntDone) begin
                    state_d = ST_WR_HOLD;
                    cnt_d   = WR_HOLD_CYC;
                end
            end
            ST_WR_HOLD: begin
                if (cntDone) begin
                    state_d = secondPend_q ? ST_WR_SETUP : ST_IDLE;
                    cnt_d   = WR_SETUP_CYC;
                end
            end
            ST_RST_LOW: begin
                if (cntDone) begin
                    state_d = ST_RST_RDY;
                    cnt_d   = RST_READY_CYC;
                end
            end
            ST_RST_RDY: begin
                if (rbStable_q | rdyTmo) begin
                    state_d = ST_RST_HOLD;
                    cnt_d   = RST_TO_READ_CYC;
                end
            end
            ST_RST_HOLD: begin
                if (cntDone) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // State and counter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= 12'h0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Second cycle of an accelerated program is pending during the first
    always_ff @(posedge core_clk) begin
        if (rst) begin
            secondPend_q <= 1'b0;
        end else if (goOk) begin
            secondPend_q <= needAcc;
        end else if ((state_q == ST_WR_HOLD) & cntDone) begin
            secondPend_q <= 1'b0;
        end
    end

    // Read capture after the access time
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdataReg_q <= '0;
        end else if ((state_q == ST_RD_WAIT) & cntDone) begin
            rdataReg_q <= dqS3_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered pin drive

    wire inRead  = (state_d == ST_RD_WAIT);
    wire inWrite = (state_d == ST_WR_SETUP) | (state_d == ST_WR_PULSE) |
                   (state_d == ST_WR_HOLD);
    wire inRstLo = (state_d == ST_RST_LOW);
    wire firstWr = secondPend_q | (goOk & needAcc);
    wire [DATA_W-1:0] wrWord = firstWr ? wdataReg_q[31:16] : wdataReg_q[DATA_W-1:0];

    // Pin registers follow the next state, so pins change with the state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            flashCeN      <= 1'b1;
            flashOeN      <= 1'b1;
            flashWeN      <= 1'b1;
            flashRestartN <= 1'b1;
            flashAddr     <= '0;
            dqOut         <= '0;
            dqOe          <= 1'b0;
        end else begin
            flashCeN      <= ~(inRead | inWrite);
            flashOeN      <= ~inRead;
            flashWeN      <= ~(state_d == ST_WR_PULSE);
            flashRestartN <= ~inRstLo;
            flashAddr     <= (inRead | inWrite) ? addrReg_q : flashAddr;
            dqOut         <= inWrite ? wrWord : dqOut;
            dqOe          <= inWrite;
        end
    end

    // Protect/accelerate pin: both drives always defined
    always_ff @(posedge core_clk) begin
        if (rst) begin
            protectAccelLevel  <= CTRL_WP_RST;
            highAccelVoltageEn <= CTRL_ACCEL_RST;
        end else begin
            protectAccelLevel  <= wpLevel_q;
            highAccelVoltageEn <= accelEn_q;
        end
    end

endmodule

`default_nettype wire

/* bench/pfm_host_ctrl_assertions.sv */
// Concurrent checks on the flash pin sequencing of the host controller
`timescale 1ns/100ps
`default_nettype none

module pfm_host_ctrl_assertions
    import pfm_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              rst,
    // Flash pins
    input wire logic              flashCeN,
    input wire logic              flashOeN,
    input wire logic              flashWeN,
    input wire logic              flashRestartN,
    input wire logic [ADDR_W-1:0] flashAddr,
    input wire logic              highAccelVoltageEn,
    // Data lines
    input wire logic [DATA_W-1:0] dqOut,
    input wire logic              dqOe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [7:0] lowCnt_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Length of the current restart pulse, saturating
    always_ff @(posedge core_clk) begin
        if (rst || flashRestartN) begin
            lowCnt_q <= 8'h00;
        end else if (lowCnt_q != 8'hff) begin
            lowCnt_q <= lowCnt_q + 8'h01;
        end
    end

    // Read strobe held with a steady address
    sequence readHold;
        (!flashOeN && !flashCeN && $stable(flashAddr))[*8];
    endsequence
    // Write strobe held with steady data on the lines
    sequence wrPulse;
        (!flashWeN && dqOe && $stable(dqOut))[*4];
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    AST_WRITE_LEVELS: assert property (!flashWeN |-> !flashCeN && flashOeN)
        else $error("write strobe without select or with output enable low");
    AST_DRIVE_OE_HIGH: assert property (dqOe |-> flashOeN)
        else $error("host drives data while output enable is low");
    AST_HV_NO_READ: assert property (highAccelVoltageEn |-> flashOeN)
        else $error("read strobe while high voltage applied");
    AST_READ_ACCESS: assert property ($fell(flashOeN) |=> readHold)
        else $error("read cycle shorter than access time");
    AST_WRITE_PULSE: assert property ($fell(flashWeN) |-> wrPulse)
        else $error("write pulse too short or data moved");
    AST_RESTART_WIDTH: assert property ($rose(flashRestartN) |-> lowCnt_q >= 8'h3f)
        else $error("restart pulse shorter than minimum");
    AST_RESTART_QUIET: assert property (!flashRestartN |-> flashCeN && flashWeN)
        else $error("cycle issued during restart pulse");
    AST_RESTART_TO_READ: assert property ($rose(flashRestartN) |-> flashCeN[*7])
        else $error("select too soon after restart release");
    AST_READ_END: assert property ($rose(flashOeN) |-> flashCeN)
        else $error("select left low after a read");

endmodule

`default_nettype wire

/* bench/pfm_flash_model.sv */
// Behavioural model of the parallel flash seen from its pins
`timescale 1ns/100ps
`default_nettype none

module pfm_flash_model #(
    parameter int          ADDR_W  = 21,
    parameter logic [15:0] ID_CODE = 16'h5a3c, // Arbitrary identification value
    parameter int          BUSY_NS = 4000,
    parameter int          ACC_NS  = 70
) (
    // Control pins
    input wire logic              ceN,
    input wire logic              oeN,
    input wire logic              weN,
    input wire logic              restartN,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              highVolt,
    // Data lines and status
    input wire logic [15:0]       dqHost,
    output logic [15:0]           dqDev,
    output logic                  readyBusyN
);
    logic [15:0] mem [int];
    logic [15:0] lastOut = 16'h0000;
    logic        idMode = 1'b0;
    logic        halfDone = 1'b0;
    int          writeCount = 0;

    initial readyBusyN = 1'b1;

    // Select and output enable must stand the access time before data is valid
    wire selValid;
    assign #(ACC_NS) selValid = !ceN && !oeN && restartN;

    ////////////////////////////////////////////////////////////////////////////////
    // Output array or code while selected, else the complement of the last value output
    always @* begin
        if (selValid && !ceN && !oeN && restartN) begin
            dqDev = idMode ? ID_CODE : (mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hffff);
            lastOut = dqDev;
        end else begin
            dqDev = ~lastOut;
        end
    end

    // Latch commands on the rising write strobe
    always @(posedge weN) begin
        if (!ceN && restartN) begin
            writeCount++;
            if (highVolt && halfDone) begin
                mem[int'(addr)] = dqHost;
                halfDone = 1'b0;
                readyBusyN = 1'b0;
                readyBusyN <= #(BUSY_NS) 1'b1;
            end else if (highVolt) begin
                halfDone = 1'b1;
            end else begin
                idMode = (dqHost == 16'h0090);
            end
        end
    end

    // Restart and voltage removal return to plain array reads
    always @(negedge restartN or negedge highVolt) begin
        idMode = 1'b0;
        halfDone = 1'b0;
    end

endmodule

`default_nettype wire

/* bench/test_pfm_host_ctrl.sv */
// Self-checking testbench of the parallel flash host controller
`timescale 1ns/100ps
`default_nettype none

module test_pfm_host_ctrl
    import pfm_pkg::*;
;
    logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic flashCeN, flashOeN, flashWeN, flashRestartN, readyBusyN, protectAccelLevel;
    logic highAccelVoltageEn, dqOe;
    logic [20:0] flashAddr;
    logic [15:0] dqIn, dqOut, dqDev;
    int num_errors = 0;
    int checks = 0;

    assign hready = hreadyout;
    assign dqIn = dqOe ? dqOut : dqDev;

    pfm_host_ctrl uut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flashCeN(flashCeN),
        .flashOeN(flashOeN), .flashWeN(flashWeN), .flashRestartN(flashRestartN),
        .flashAddr(flashAddr), .readyBusyN(readyBusyN), .protectAccelLevel(protectAccelLevel),
        .highAccelVoltageEn(highAccelVoltageEn), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

    pfm_flash_model flash (.ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN),
        .restartN(flashRestartN), .addr(flashAddr), .highVolt(highAccelVoltageEn),
        .dqHost(dqOut), .dqDev(dqDev), .readyBusyN(readyBusyN));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single AHB-Lite transfer
    task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                       output logic [31:0] rd);
        haddr <= {24'h000000, ofs};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, ofs, d, r);
    endtask

    task automatic rdchk(input logic [7:0] ofs, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, ofs, 32'h0, r);
        check(r & mask, exp);
    endtask

    // Start an operation and poll until the controller is idle
    task automatic go(input logic [31:0] ctrl);
        logic [31:0] s;
        int n;
        wr(CTRL_OFS, ctrl);
        n = 0;
        do begin
            bus(1'b0, STATUS_OFS, 32'h0, s);
            n++;
        end while (s[0] !== 1'b0 && n < 4000);
        check({31'h0, s[0]}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, unmapped space and pin levels
    task automatic t_regs();
        check({31'h0, protectAccelLevel}, 32'h1);
        rdchk(CTRL_OFS, 32'hffffffff, 32'h10);
        wr(8'h20, 32'hdeadbeef);
        rdchk(8'h20, 32'hffffffff, 32'h0);
        rdchk(STATUS_OFS, 32'h1d, 32'h0);
        wr(CTRL_OFS, 32'h0);
        repeat (2) @(posedge core_clk);
        check({31'h0, protectAccelLevel}, 32'h0);
    endtask

    // Accelerated programming, refusals and read while the flash is busy
    task automatic t_accel();
        int n;
        wr(CTRL_OFS, 32'h19);
        rdchk(STATUS_OFS, 32'h14, 32'h14);
        wr(STATUS_OFS, 32'h10);
        wr(ADDR_OFS, 32'h100);
        wr(WDATA_OFS, 32'h00a0_1234);
        n = flash.writeCount;
        go(32'h1d);
        check(flash.writeCount - n, 32'h2);
        rdchk(STATUS_OFS, 32'h2, 32'h0);
        wr(CTRL_OFS, 32'h10);
        repeat (2) @(posedge core_clk);
        check({31'h0, highAccelVoltageEn}, 32'h0);
        go(32'h11);
        rdchk(RDATA_OFS, 32'hffff, 32'h1234);
        wr(CTRL_OFS, 32'h15);
        rdchk(STATUS_OFS, 32'h10, 32'h10);
        wr(STATUS_OFS, 32'h10);
        rdchk(STATUS_OFS, 32'h10, 32'h0);
    endtask

    // Restart while busy, restart while idle, then array reads
    task automatic t_restart();
        go(32'h17);
        rdchk(STATUS_OFS, 32'h0a, 32'h0a);
        wr(STATUS_OFS, 32'h08);
        go(32'h17);
        rdchk(STATUS_OFS, 32'h0a, 32'h02);
        go(32'h11);
        rdchk(RDATA_OFS, 32'hffff, 32'h1234);
    endtask

    // Identification mode entry and exit
    task automatic t_ident();
        wr(ADDR_OFS, 32'h555);
        wr(WDATA_OFS, 32'h0090);
        go(32'h13);
        go(32'h11);
        rdchk(RDATA_OFS, 32'hffff, 32'h5a3c);
        wr(WDATA_OFS, 32'h00f0);
        go(32'h13);
        wr(ADDR_OFS, 32'h100);
        go(32'h11);
        rdchk(RDATA_OFS, 32'hffff, 32'h1234);
    endtask

    task automatic tally_and_finish();
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Watchdog against a hang
    initial begin
        #400000;
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_accel();
        t_restart();
        t_ident();
        tally_and_finish();
    end

endmodule

bind pfm_host_ctrl pfm_host_ctrl_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (
    .core_clk(core_clk), .rst(rst), .flashCeN(flashCeN), .flashOeN(flashOeN),
    .flashWeN(flashWeN), .flashRestartN(flashRestartN), .flashAddr(flashAddr),
    .highAccelVoltageEn(highAccelVoltageEn), .dqOut(dqOut), .dqOe(dqOe));

`default_nettype wire
